// file: grp_pkg.sv
package grp_pkg;

  // ****************************************************************
  // command word values
  // ****************************************************************
  localparam logic [15:0] CMD_IDLE  = 16'h0000;
  localparam logic [15:0] CMD_XFER  = 16'h0001;
  localparam logic [15:0] CMD_CLOSE = 16'h0200;
  localparam logic [15:0] CMD_ACK   = 16'h8000;

  // ****************************************************************
  // state word bit positions
  // ****************************************************************
  localparam int SW_ERROR     = 15;
  localparam int SW_ACCEPTED  = 12;
  localparam int SW_UNDEF_POS = 11;
  localparam int SW_INNER_POS = 10;
  localparam int SW_OUTER_POS = 8;
  localparam int SW_ALIVE     = 6;

  // ****************************************************************
  // position scale and travel limits
  // ****************************************************************
  localparam logic [15:0] POS_OUTER      = 16'h0000;
  localparam logic [15:0] POS_INNER      = 16'h07D0;
  localparam int          POS_LSB_UM     = 10;
  localparam int          MIN_TRAVEL_UM  = 500;
  localparam logic [15:0] MIN_TRAVEL_CNT = 16'(MIN_TRAVEL_UM / POS_LSB_UM);

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [15:0] WORD_RST  = 16'h0000;
  localparam logic [7:0]  PARAM_RST = 8'h00;

  typedef enum logic [1:0] {
    HS_BOOT   = 2'b00,
    HS_NOPARM = 2'b01,
    HS_ACCEPT = 2'b10,
    HS_READY  = 2'b11
  } grp_hs_t;

endpackage

// file: grp_fault_if.sv
`timescale 1ns/10ps
interface grp_fault_if;
  logic        fault_detect;
  logic [15:0] fault_id;
  logic        ack_req;
  logic        error_flag;
  logic [15:0] code;

  modport tracker (
    input  fault_detect,
    input  fault_id,
    input  ack_req,
    output error_flag,
    output code
  );

  modport user (
    output fault_detect,
    output fault_id,
    output ack_req,
    input  error_flag,
    input  code
  );
endinterface

// file: grp_fault_latch.sv
`timescale 1ns/10ps
module grp_fault_latch (
  input wire logic       clk,
  input wire logic       arst_n,
  grp_fault_if.tracker   flt
);

  logic        error_reg;
  logic [15:0] code_reg;

  // a fault present in the ack cycle keeps the flag: set wins over clear
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      error_reg <= 1'b0;
    else if (flt.fault_detect)
      error_reg <= 1'b1;
    else if (flt.ack_req)
      error_reg <= 1'b0;
  end

  // code holds the first fault until acknowledged, zero when clear
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      code_reg <= grp_pkg::WORD_RST;
    else if (flt.fault_detect && (!error_reg || flt.ack_req))
      code_reg <= flt.fault_id;
    else if (flt.ack_req && !flt.fault_detect)
      code_reg <= grp_pkg::WORD_RST;
  end

  assign flt.error_flag = error_reg;
  assign flt.code       = code_reg;

endmodule

// file: grp_process_data.sv
`timescale 1ns/10ps
module grp_process_data (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        boot_done,
  input  wire logic [15:0] command_word,
  input  wire logic [7:0]  grip_profile_select,
  input  wire logic [7:0]  force_level,
  input  wire logic        fault_detect,
  input  wire logic [15:0] fault_id,
  input  wire logic [15:0] jaw_sensor,
  output logic      [15:0] state_word,
  output logic      [15:0] fault_code,
  output logic      [15:0] measured_jaw_position,
  output logic      [7:0]  profile_active,
  output logic      [7:0]  force_active,
  output logic             close_jaws_command,
  output logic             move_refused
);

  // ****************************************************************
  // fault tracking
  // ****************************************************************
  grp_fault_if flt ();

  assign flt.fault_detect = fault_detect;
  assign flt.fault_id     = fault_id;
  assign flt.ack_req      = (command_word == grp_pkg::CMD_ACK);

  grp_fault_latch u_fault (
    .clk    (clk),
    .arst_n (arst_n),
    .flt    (flt)
  );

  // ****************************************************************
  // handshake state
  // ****************************************************************
  grp_pkg::grp_hs_t hs_reg;
  grp_pkg::grp_hs_t hs_next;

  always_comb
  begin
    hs_next = hs_reg;
    unique case (hs_reg)
      grp_pkg::HS_BOOT:
        if (boot_done)
          hs_next = grp_pkg::HS_NOPARM;
      grp_pkg::HS_NOPARM, grp_pkg::HS_READY:
        if (command_word == grp_pkg::CMD_XFER)
          hs_next = grp_pkg::HS_ACCEPT;
      grp_pkg::HS_ACCEPT:
        if (command_word == grp_pkg::CMD_IDLE)
          hs_next = grp_pkg::HS_READY;
    endcase
    // parameters are treated as stale after an acknowledge while a fault is latched
    if (hs_reg != grp_pkg::HS_BOOT && flt.ack_req && flt.error_flag)
      hs_next = grp_pkg::HS_NOPARM;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      hs_reg <= grp_pkg::HS_BOOT;
    else
      hs_reg <= hs_next;
  end

  // parameters are taken on entry to the accepted state only
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      profile_active <= grp_pkg::PARAM_RST;
      force_active   <= grp_pkg::PARAM_RST;
    end
    else if (hs_reg != grp_pkg::HS_ACCEPT && hs_next == grp_pkg::HS_ACCEPT)
    begin
      profile_active <= grip_profile_select;
      force_active   <= force_level;
    end
  end

  // ****************************************************************
  // position and motion
  // ****************************************************************
  logic [15:0] pos_clamped;
  logic        travel_ok;
  logic        close_ok;

  // sensor overshoot must not leak past the inner limit
  assign pos_clamped = (jaw_sensor > grp_pkg::POS_INNER) ? grp_pkg::POS_INNER
                                                         : jaw_sensor;
  assign travel_ok   = (grp_pkg::POS_INNER - pos_clamped) >= grp_pkg::MIN_TRAVEL_CNT;
  assign close_ok    = (hs_reg == grp_pkg::HS_READY) && !flt.error_flag
                       && (command_word == grp_pkg::CMD_CLOSE);

  // once started, the move runs to the limit while the command is held and no fault is latched
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      close_jaws_command <= 1'b0;
    else if (!close_ok || pos_clamped == grp_pkg::POS_INNER)
      close_jaws_command <= 1'b0;
    else if (travel_ok)
      close_jaws_command <= 1'b1;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      move_refused <= 1'b0;
    else
      move_refused <= close_ok && !close_jaws_command && !travel_ok;
  end

  // ****************************************************************
  // published process data
  // ****************************************************************
  logic [15:0] state_word_next;

  always_comb
  begin
    state_word_next                        = grp_pkg::WORD_RST;
    state_word_next[grp_pkg::SW_ERROR]     = flt.error_flag;
    state_word_next[grp_pkg::SW_ACCEPTED]  = (hs_reg == grp_pkg::HS_ACCEPT);
    state_word_next[grp_pkg::SW_ALIVE]     = 1'b1;
    state_word_next[grp_pkg::SW_OUTER_POS] = (pos_clamped == grp_pkg::POS_OUTER);
    state_word_next[grp_pkg::SW_INNER_POS] = (pos_clamped == grp_pkg::POS_INNER);
    state_word_next[grp_pkg::SW_UNDEF_POS] = (pos_clamped != grp_pkg::POS_OUTER)
                                             && (pos_clamped != grp_pkg::POS_INNER);
  end

  // nothing is published before boot, so a zero alive bit means not ready
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_word            <= grp_pkg::WORD_RST;
      fault_code            <= grp_pkg::WORD_RST;
      measured_jaw_position <= grp_pkg::WORD_RST;
    end
    else if (hs_reg != grp_pkg::HS_BOOT)
    begin
      state_word            <= state_word_next;
      fault_code            <= flt.code;
      measured_jaw_position <= pos_clamped;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_error_sets: assert property (
    fault_detect && hs_reg != grp_pkg::HS_BOOT |-> ##2 state_word[15])
    else $error("error flag not raised after fault");

  // the published flag lags the latch by one edge, so an ack one cycle back still counts
  a_error_holds: assert property (
    state_word[15] && command_word != grp_pkg::CMD_ACK && hs_reg != grp_pkg::HS_BOOT
    && $past(command_word) != grp_pkg::CMD_ACK
    |=> ##1 state_word[15])
    else $error("error flag dropped without acknowledge");

  a_ack_clears: assert property (
    flt.error_flag && command_word == grp_pkg::CMD_ACK && !fault_detect
    |=> !flt.error_flag)
    else $error("acknowledge did not clear fault");

  a_code_follows: assert property (
    hs_reg != grp_pkg::HS_BOOT |=> fault_code == $past(flt.code))
    else $error("fault code not published");

  a_pos_range: assert property (measured_jaw_position <= 16'h07D0)
    else $error("position beyond inner limit");

  a_pos_follow: assert property (
    hs_reg != grp_pkg::HS_BOOT && jaw_sensor <= 16'h07D0
    |=> measured_jaw_position == $past(jaw_sensor))
    else $error("position not published");

  a_min_travel: assert property (
    $rose(close_jaws_command) |-> $past(pos_clamped) <= 16'h079E)
    else $error("move started with short travel");

  a_boot_quiet: assert property (
    hs_reg == grp_pkg::HS_BOOT |=> state_word == 16'h0000)
    else $error("data published before boot");

  a_alive_bit: assert property (
    hs_reg != grp_pkg::HS_BOOT |=> state_word[6])
    else $error("alive bit missing after boot");

  a_accept_sets: assert property (
    hs_reg != grp_pkg::HS_BOOT && hs_reg != grp_pkg::HS_ACCEPT
    && command_word == grp_pkg::CMD_XFER
    && !(flt.ack_req && flt.error_flag) |-> ##2 state_word[12])
    else $error("accepted flag not raised");

  a_accept_clears: assert property (
    hs_reg == grp_pkg::HS_ACCEPT && command_word == grp_pkg::CMD_IDLE
    |-> ##2 !state_word[12])
    else $error("accepted flag not cleared");

  a_close_gate: assert property (
    close_jaws_command |-> $past(hs_reg) == grp_pkg::HS_READY
    && $past(command_word) == grp_pkg::CMD_CLOSE)
    else $error("close without completed handshake");

  c_handshake: cover property (
    hs_reg == grp_pkg::HS_ACCEPT ##[1:20] hs_reg == grp_pkg::HS_READY);
  c_close: cover property ($rose(close_jaws_command));
  c_fault_ack: cover property (flt.error_flag ##[1:20] !flt.error_flag);
  c_refused: cover property (move_refused);

endmodule

// file: grp_plc_model.sv
`timescale 1ns/10ps
// ****************************************************************
// host side: runs the transfer handshake when asked, else passes user_cmd
// ****************************************************************
module grp_plc_model (
  input  wire logic        clk,
  input  wire logic        start_xfer,
  input  wire logic [15:0] user_cmd,
  input  wire logic [15:0] state_word,
  output logic      [15:0] command_word,
  output logic             xfer_done
);
  logic [15:0] seq_cmd;
  int          polls;

  assign command_word = start_xfer ? seq_cmd : user_cmd;

  initial
  begin
    seq_cmd   = grp_pkg::CMD_IDLE;
    xfer_done = 1'b0;
    forever
    begin
      @(negedge clk);
      if (!start_xfer)
        xfer_done = 1'b0;
      else if (!xfer_done)
      begin
        polls = 0;
        while (!state_word[grp_pkg::SW_ALIVE] && polls < 40)
        begin
          @(negedge clk);
          polls++;
        end
        seq_cmd = grp_pkg::CMD_XFER;
        while (!state_word[grp_pkg::SW_ACCEPTED] && polls < 40)
        begin
          @(negedge clk);
          polls++;
        end
        seq_cmd = grp_pkg::CMD_IDLE;
        while (state_word[grp_pkg::SW_ACCEPTED] && polls < 40)
        begin
          @(negedge clk);
          polls++;
        end
        // a stalled exchange leaves done low so the bench timeout reports it
        xfer_done = (polls < 40);
      end
    end
  end
endmodule

// file: testbench.sv
`timescale 1ns/10ps
module testbench;
  logic        clk, arst_n, boot_done, fault_detect, start_xfer, xfer_done;
  logic        close_jaws_command, move_refused;
  logic [15:0] user_cmd, command_word, fault_id, jaw_sensor;
  logic [15:0] state_word, fault_code, measured_jaw_position;
  logic [7:0]  grip_profile_select, force_level, profile_active, force_active;
  int          bad_count, comparisons;

  grp_process_data grp_process_data_i (.clk(clk), .arst_n(arst_n), .boot_done(boot_done),
    .command_word(command_word), .grip_profile_select(grip_profile_select),
    .force_level(force_level), .fault_detect(fault_detect), .fault_id(fault_id),
    .jaw_sensor(jaw_sensor), .state_word(state_word), .fault_code(fault_code),
    .measured_jaw_position(measured_jaw_position), .profile_active(profile_active),
    .force_active(force_active), .close_jaws_command(close_jaws_command),
    .move_refused(move_refused));

  grp_plc_model grp_plc_model_i (.clk(clk), .start_xfer(start_xfer), .user_cmd(user_cmd),
    .state_word(state_word), .command_word(command_word), .xfer_done(xfer_done));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // a write: command held long enough for the two-edge answer to settle
  task automatic send(input logic [15:0] c);
    user_cmd = c;
    cyc(3);
  endtask

  task automatic handshake(input logic [7:0] prof, input logic [7:0] frc);
    int i;
    grip_profile_select = prof;
    force_level         = frc;
    start_xfer          = 1'b1;
    for (i = 0; i < 100 && xfer_done !== 1'b1; i++) @(negedge clk);
    if (xfer_done !== 1'b1)
    begin
      $display("wrong value at %0t: handshake never completed", $time);
      bad_count++;
      close_out();
    end
    start_xfer = 1'b0;
    cyc(2);
  endtask

  initial
  begin
    arst_n = 1'b0; boot_done = 1'b0; fault_detect = 1'b0; start_xfer = 1'b0;
    user_cmd = 16'h0000; fault_id = 16'h0000; jaw_sensor = 16'h03E8;
    grip_profile_select = 8'h00; force_level = 8'h00;
    bad_count = 0; comparisons = 0;
    cyc(16);
    check(state_word, 16'h0000);
    arst_n = 1'b1;
    send(grp_pkg::CMD_XFER);
    check(state_word, 16'h0000);
    send(grp_pkg::CMD_IDLE);
    boot_done = 1'b1;
    cyc(3);
    check(state_word, 16'h0840);
    check(measured_jaw_position, 16'h03E8);
    check(fault_code, 16'h0000);
    jaw_sensor = 16'h0834;
    cyc(3);
    check(measured_jaw_position, 16'h07D0);
    check(state_word, 16'h0440);
    jaw_sensor = 16'h0000;
    cyc(3);
    check(state_word, 16'h0140);
    jaw_sensor = 16'h03E8;
    send(grp_pkg::CMD_CLOSE);
    check({15'h0000, close_jaws_command}, 16'h0000);
    send(grp_pkg::CMD_IDLE);
    handshake(8'h64, 8'h04);
    check({profile_active, force_active}, 16'h6404);
    check(state_word, 16'h0840);
    // 39 counts short of the inner limit: below minimum travel
    jaw_sensor = 16'h07A9;
    send(grp_pkg::CMD_CLOSE);
    check({14'h0000, move_refused, close_jaws_command}, 16'h0002);
    send(grp_pkg::CMD_IDLE);
    jaw_sensor = 16'h079E;
    send(grp_pkg::CMD_CLOSE);
    check({14'h0000, move_refused, close_jaws_command}, 16'h0001);
    jaw_sensor = 16'h07D0;
    cyc(3);
    check({15'h0000, close_jaws_command}, 16'h0000);
    send(grp_pkg::CMD_IDLE);
    jaw_sensor = 16'h03E8;
    fault_detect = 1'b1;
    fault_id = 16'h0307;
    cyc(3);
    check(state_word, 16'h8840);
    check(fault_code, 16'h0307);
    fault_detect = 1'b0;
    cyc(4);
    check(state_word, 16'h8840);
    send(grp_pkg::CMD_ACK);
    check(state_word, 16'h0840);
    check(fault_code, 16'h0000);
    send(grp_pkg::CMD_IDLE);
    send(grp_pkg::CMD_CLOSE);
    check({15'h0000, close_jaws_command}, 16'h0000);
    send(grp_pkg::CMD_IDLE);
    handshake(8'h46, 8'h01);
    check({profile_active, force_active}, 16'h4601);
    send(grp_pkg::CMD_CLOSE);
    check({15'h0000, close_jaws_command}, 16'h0001);
    close_out();
  end
endmodule
